//--- bench/stdc_cpu_model.sv
// Processor bus model: starts a new bus cycle after each phase clock fall.
// Assumes the bench supplies the next request; halt is active low.
`timescale 1ns/1ps
module stdc_cpu_model (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic phaseClk,
  input wire logic haltN,
  input wire stdc_pkg::stdc_cpu_req_t nextReq,
  input wire logic [7:0] nextData,
  output stdc_pkg::stdc_cpu_req_t busReq,
  output logic [7:0] busData
);
  logic phaseD_r;
  logic vecDone_r;
  logic busFloat;
  logic [1:0] intMask_r;
  // Float control input held low for good
  assign busFloat = 1'b0;
  // Bus pins change one clock after the phase clock falls
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      phaseD_r <= 1'b0;
      vecDone_r <= 1'b0;
      // Normal and fast masks set; no request line, so no other vector is taken
      intMask_r <= 2'h3;
      busReq <= '{addr: 16'hfffe, readNotWrite: 1'b1};
      busData <= 8'h00;
    end else begin
      phaseD_r <= phaseClk;
      if (phaseD_r && !phaseClk && !busFloat && intMask_r == 2'h3) begin
        busData <= ~busData;
        vecDone_r <= 1'b1;
        if (!vecDone_r || !haltN) begin
          busReq <= '{addr: 16'hffff, readNotWrite: 1'b1};
        end else begin
          busReq <= nextReq;
          if (!nextReq.readNotWrite) begin
            busData <= nextData;
          end
        end
      end
    end
  end
endmodule : stdc_cpu_model

//--- bench/stdc_top_asserts.sv
// Checker for the timing and memory control block.
// Assumes it is bound to stdc_top and sees only its ports.
`timescale 1ns/1ps
module stdc_top_asserts (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [15:0] cpuAddr,
  input wire logic cpuReadNotWrite,
  input wire logic phaseClk,
  input wire logic quadClk,
  input wire logic [7:0] muxedMemAddr,
  input wire logic [2:0] physBankAddr,
  input wire logic [15:0] videoAddr,
  input wire logic rowStrobeN,
  input wire logic colStrobeN,
  input wire logic bank0_write_enable_nOut,
  input wire logic bank1_write_enable_nOut,
  input wire logic romEnableN,
  input wire logic refreshActive
);
  default clocking dc @(posedge mclk);
  endclocking
  default disable iff (sys_rst);
  logic weLow;
  // Either bank write enable asserted
  assign weLow = !bank0_write_enable_nOut || !bank1_write_enable_nOut;
  //////////////////////////////////////////////////////////////////////////////
  quad_rise_a: assert property ($rose(phaseClk) |-> quadClk)
    else $error("quad clock low at phase rise");
  quad_fall_a: assert property ($fell(phaseClk) |-> !quadClk)
    else $error("quad clock high at phase fall");
  row_first_a: assert property ($fell(rowStrobeN) |-> colStrobeN ##0 (!rowStrobeN)[*3])
    else $error("row strobe not alone or too short");
  col_after_a: assert property ($fell(rowStrobeN) && phaseClk |-> ##[1:6] $fell(colStrobeN))
    else $error("column strobe late");
  col_in_row_a: assert property (!colStrobeN |-> !rowStrobeN)
    else $error("column strobe without row strobe");
  row_addr_a: assert property ($fell(rowStrobeN) && phaseClk |-> muxedMemAddr == cpuAddr[7:0])
    else $error("row byte wrong");
  col_addr_a: assert property ($fell(colStrobeN) && phaseClk |-> muxedMemAddr == cpuAddr[15:8])
    else $error("column byte wrong");
  we_early_a: assert property ($fell(colStrobeN) && phaseClk && !cpuReadNotWrite && !cpuAddr[15]
    |-> $past(weLow) && weLow)
    else $error("write enable not before column strobe");
  bank_pick_a: assert property (weLow |-> bank1_write_enable_nOut == !physBankAddr[0])
    else $error("write enable on the wrong bank");
  video_row_a: assert property ($fell(rowStrobeN) && !phaseClk && !refreshActive
    |-> muxedMemAddr == videoAddr[7:0])
    else $error("video row byte wrong");
  read_no_we_a: assert property (weLow |-> phaseClk && !cpuReadNotWrite && !cpuAddr[15])
    else $error("write enable outside a cpu write");
  one_bank_a: assert property (bank0_write_enable_nOut || bank1_write_enable_nOut)
    else $error("both banks written");
  rom_in_e_a: assert property (!romEnableN |-> phaseClk && cpuReadNotWrite)
    else $error("rom enabled outside read high phase");
  refresh_slot_a: assert property (refreshActive |-> !phaseClk && colStrobeN)
    else $error("refresh in cpu slot or with column strobe");
  // Main scenarios reached
  cover property ($fell(colStrobeN) && !cpuReadNotWrite);
  cover property (!romEnableN);
  cover property ($rose(refreshActive));
  cover property ($fell(bank1_write_enable_nOut));
endmodule : stdc_top_asserts

bind stdc_top stdc_top_asserts i_chk (.mclk(mclk), .sys_rst(sys_rst), .cpuAddr(cpuAddr),
  .cpuReadNotWrite(cpuReadNotWrite), .phaseClk(phaseClk), .quadClk(quadClk),
  .muxedMemAddr(muxedMemAddr), .rowStrobeN(rowStrobeN), .colStrobeN(colStrobeN),
  .physBankAddr(physBankAddr), .videoAddr(videoAddr),
  .bank0_write_enable_nOut(bank0_write_enable_nOut), .romEnableN(romEnableN),
  .bank1_write_enable_nOut(bank1_write_enable_nOut), .refreshActive(refreshActive));

//--- bench/test_system_timing_dram_control.sv
// Self-checking bench for the timing and memory control block.
// Assumes the processor model and the bound checker are compiled first.
`timescale 1ns/1ps
module test_system_timing_dram_control;
  localparam logic [15:0] CORNER [8] = '{16'h7fff, 16'h8000, 16'hbfff, 16'hc000,
    16'hfeff, 16'hff00, 16'hff3f, 16'hff40};
  logic mclk, sys_rst, masterOsc, fastSpeed, haltN, colourRef, phaseClk, quadClk;
  logic rowStrobeN, colStrobeN, we0N, we1N, romEnableN, refreshActive;
  logic [7:0] nextData, cpuData, muxedMemAddr, row;
  logic [15:0] videoAddr, a;
  logic [2:0] physBankAddr, selectCode;
  stdc_pkg::stdc_cpu_req_t nextReq, busReq;
  int failures, compares;
  logic [5:0] pageTab [8];
  logic [7:0] pageSet;
  realtime t0, t1, t2;
  //////////////////////////////////////////////////////////////////////////////
  stdc_top #(.REFRESH_PERIOD(150)) i_dut (.mclk(mclk), .sys_rst(sys_rst),
    .masterOsc(masterOsc), .fastSpeed(fastSpeed), .cpuAddr(busReq.addr),
    .cpuReadNotWrite(busReq.readNotWrite), .cpuData(cpuData), .videoAddr(videoAddr),
    .colourRef(colourRef), .phaseClk(phaseClk), .quadClk(quadClk),
    .muxedMemAddr(muxedMemAddr), .physBankAddr(physBankAddr), .rowStrobeN(rowStrobeN),
    .colStrobeN(colStrobeN), .bank0_write_enable_nOut(we0N),
    .bank1_write_enable_nOut(we1N), .selectCode(selectCode), .romEnableN(romEnableN),
    .refreshActive(refreshActive));
  stdc_cpu_model i_cpu (.mclk(mclk), .sys_rst(sys_rst), .phaseClk(phaseClk),
    .haltN(haltN), .nextReq(nextReq), .nextData(nextData), .busReq(busReq), .busData(cpuData));
  // System clock and an unrelated master oscillator
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  initial begin
    masterOsc = 1'b0;
    forever #17.5 masterOsc = ~masterOsc;
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic tick();
    @(posedge mclk);
    #1;
  endtask : tick
  task automatic close_out();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : close_out
  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check
  function automatic logic pick(input int which);
    case (which)
      0: return phaseClk;
      1: return colourRef;
      2: return refreshActive;
      3: return colStrobeN;
      default: return rowStrobeN;
    endcase
  endfunction : pick
  // Bounded wait for a level on one of the watched outputs
  task automatic wait_for(input int which, input logic lvl);
    for (int k = 0; pick(which) !== lvl; k++) begin
      if (k > 400) begin
        failures++;
        $display("wrong value at %0t: wait %0d timed out", $time, which);
        close_out();
      end
      tick();
    end
  endtask : wait_for
  function automatic logic [2:0] exp_sel(input logic [15:0] ad);
    if (ad >= 16'hff00 && ad <= 16'hff3f) return 3'h1;
    if (ad >= 16'hc000 && ad <= 16'hfeff) return 3'h2;
    if (ad >= 16'h8000 && ad <= 16'hbfff) return 3'h0;
    return 3'h7;
  endfunction : exp_sel
  function automatic logic near(input realtime v, input realtime e, input realtime tol);
    return v >= e - tol && v <= e + tol;
  endfunction : near
  // One processor access, watched through its high phase
  task automatic cpu_cycle(input logic [15:0] ad, input logic rw);
    logic [2:0] sel, bank;
    logic romSeen, we0Seen, we1Seen, upper;
    nextReq = '{addr: ad, readNotWrite: rw};
    nextData = 8'($urandom);
    // Paging writes land in the first high phase, before the watched one
    if (!rw && ad >= 16'hffa0 && ad <= 16'hffa7) begin
      pageTab[ad[2:0]] = nextData[5:0];
      pageSet[ad[2:0]] = 1'b1;
    end
    upper = pageTab[ad[15:13]][3];
    wait_for(0, 1'b1);
    wait_for(0, 1'b0);
    wait_for(0, 1'b1);
    romSeen = 1'b0;
    we0Seen = 1'b0;
    we1Seen = 1'b0;
    wait_for(3, 1'b0);
    sel = selectCode;
    bank = physBankAddr;
    // New video address well clear of the next video slot
    videoAddr = 16'($urandom);
    for (int k = 0; k < 300 && phaseClk === 1'b1; k++) begin
      romSeen |= romEnableN === 1'b0;
      we0Seen |= we0N === 1'b0;
      we1Seen |= we1N === 1'b0;
      tick();
    end
    wait_for(0, 1'b0);
    check(sel, exp_sel(ad), "select code");
    check(romSeen, exp_sel(ad) == 3'h0 && rw, "rom enable");
    check(we0Seen, !rw && !ad[15] && !upper, "bank0 write enable");
    check(we1Seen, !rw && !ad[15] && upper, "bank1 write enable");
    if (pageSet[ad[15:13]]) check(bank, pageTab[ad[15:13]][5:3], "physical bank");
  endtask : cpu_cycle
  //////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    sys_rst = 1'b1;
    fastSpeed = 1'b0;
    haltN = 1'b1;
    nextReq = '0;
    nextData = 8'h00;
    videoAddr = 16'h0000;
    failures = 0;
    compares = 0;
    pageSet = 8'h00;
    void'($urandom(32'h57ab));
    repeat (5) tick();
    check({rowStrobeN, colStrobeN, we0N, we1N, romEnableN, phaseClk, selectCode}, 16'h01f7,
      "reset outputs");
    sys_rst = 1'b0;
    for (int s = 0; s < 2; s++) begin
      fastSpeed = s[0];
      repeat (3) begin
        wait_for(0, 1'b1);
        wait_for(0, 1'b0);
      end
      wait_for(0, 1'b1);
      t0 = $realtime;
      wait_for(0, 1'b0);
      t1 = $realtime;
      wait_for(0, 1'b1);
      t2 = $realtime;
      check(near(t1 - t0, t2 - t1, 20), 16'h0001, "phase duty");
      check(near(t2 - t0, s ? 560 : 1120, 10), 16'h0001, "phase period");
      wait_for(1, 1'b0);
      wait_for(1, 1'b1);
      t0 = $realtime;
      wait_for(1, 1'b0);
      wait_for(1, 1'b1);
      check(near($realtime - t0, 280, 10), 16'h0001, "reference period");
    end
    // Fill the paging entries that the processor space reads
    for (int i = 0; i < 8; i++) begin
      cpu_cycle(16'hffa0 + 16'(i), 1'b0);
    end
    for (int i = 0; i < 32; i++) begin
      a = i < 8 ? CORNER[i] : 16'($urandom);
      cpu_cycle(a, i < 8 ? i[0] : 1'($urandom));
    end
    // Halted processor parks on a vector read
    haltN = 1'b0;
    repeat (2) begin
      wait_for(0, 1'b1);
      wait_for(0, 1'b0);
    end
    check(busReq.addr, 16'hffff, "halted bus");
    check(selectCode, 3'h7, "halted select");
    haltN = 1'b1;
    for (int i = 0; i < 258; i++) begin
      wait_for(2, 1'b1);
      wait_for(4, 1'b0);
      if (i > 0) check(muxedMemAddr, 8'(row + 8'h01), "refresh row");
      row = muxedMemAddr;
      wait_for(2, 1'b0);
    end
    close_out();
  end
endmodule : test_system_timing_dram_control

//--- hdl/stdc_page_mem.sv
// Paging unit memory: sixteen entries of upper physical address bits.
// Assumes writes and reads come from the same clock; read data is registered.
`timescale 1ns/1ps
module stdc_page_mem #(
  parameter int unsigned DEPTH = 16,
  parameter int unsigned WIDTH = 6
) (
  input wire logic mclk,
  input wire logic writeEn,
  input wire logic [$clog2(DEPTH)-1:0] writeIdx,
  input wire logic [WIDTH-1:0] writeData,
  input wire logic [$clog2(DEPTH)-1:0] readIdx,
  output logic [WIDTH-1:0] readData
);
  logic [WIDTH-1:0] store [DEPTH];

  // Entry storage
  always_ff @(posedge mclk) begin
    if (writeEn) begin
      store[writeIdx] <= writeData;
    end
  end

  // Registered read port
  always_ff @(posedge mclk) begin
    readData <= store[readIdx];
  end
endmodule : stdc_page_mem

//--- hdl/stdc_pkg.sv
// Shared constants and carriers for the system timing and memory control block.
// Assumes a single 100 MHz mclk domain; the master oscillator arrives as a pin.
package stdc_pkg;
  // Division ratios
  localparam int unsigned MASTER_DIV = 8;
  localparam int unsigned SLOW_DIV = 4;
  localparam int unsigned FAST_DIV = 2;
  // Master oscillator rises in one quarter of the processor clock period
  localparam int unsigned SLOW_QUARTER = MASTER_DIV * SLOW_DIV / 4;
  localparam int unsigned FAST_QUARTER = MASTER_DIV * FAST_DIV / 4;
  // Refresh timing
  localparam int unsigned REFRESH_ROWS = 256;
  localparam int unsigned REFRESH_WINDOW_MS = 4;
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned REFRESH_WINDOW_CYC = REFRESH_WINDOW_MS * 1000 * 1000 * CLK_MHZ / 1000;
  localparam int unsigned REFRESH_PERIOD_CYC = REFRESH_WINDOW_CYC / REFRESH_ROWS;
  // Paging unit decode
  localparam logic [15:0] PAGE_BASE = 16'hffa0;
  localparam logic [15:0] PAGE_LAST = 16'hffaf;
  localparam int unsigned PAGE_ENTRIES = 16;
  localparam int unsigned PAGE_BITS = 6;
  localparam int unsigned PAGE_SHIFT = 13;
  // Device select codes for the external decoder
  localparam logic [2:0] SEL_RAM = 3'h7;
  localparam logic [2:0] SEL_ROM = 3'h0;
  localparam logic [2:0] SEL_ADAPT = 3'h1;
  localparam logic [2:0] SEL_CART = 3'h2;
  localparam logic [15:0] ROM_BASE = 16'h8000;
  localparam logic [15:0] CART_BASE = 16'hc000;
  localparam logic [15:0] ADAPT_BASE = 16'hff00;
  localparam logic [15:0] ADAPT_LAST = 16'hff3f;
  localparam logic [15:0] IO_BASE = 16'hff00;

  // Processor bus request as seen by the block
  typedef struct packed {
    logic [15:0] addr;
    logic readNotWrite;
  } stdc_cpu_req_t;

  // DRAM strobe and address group
  typedef struct packed {
    logic [7:0] memAddr;
    logic rowStrobeN;
    logic colStrobeN;
    logic bank0WriteEnableN;
    logic bank1WriteEnableN;
  } stdc_dram_t;

  typedef enum logic [2:0] {ST_IDLE, ST_ROW, ST_COL, ST_HOLD, ST_DONE} stdc_phase_t;
endpackage : stdc_pkg

//--- hdl/stdc_top.sv
// System timing, address multiplex, refresh and device select logic.
// Assumes the master oscillator pin is sampled on mclk; processor pins are async.
// Functional notes
// - Master oscillator divided by eight gives the colour reference
// - Colour reference divided by four slow or two fast gives processor clocks
// - Both clocks half duty; quadrature leads phase clock by quarter period
// - Processor owns memory while phase clock high, video while low
// - Processor address reaches memory only during phase clock high
// - All sixteen processor address lines feed the multiplexed address
// - Row half with row strobe, then column half with column strobe
// - Row half carries low eight bits, column half the upper bits
// - Read cycles keep write enable high throughout
// - Write enable asserted before column strobe falls
// - Two write enables select one of two 64K banks
// - Refresh covers 256 rows within 4 ms
// - Three-line select code for an external decoder
// - ROM enabled only in phase clock high read cycles
// - Paging unit at FFA0-FFAF supplies upper physical address bits
`timescale 1ns/1ps
module stdc_top #(
  parameter int unsigned REFRESH_PERIOD = stdc_pkg::REFRESH_PERIOD_CYC
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic masterOsc,
  input wire logic fastSpeed,
  input wire logic [15:0] cpuAddr,
  input wire logic cpuReadNotWrite,
  input wire logic [7:0] cpuData,
  input wire logic [15:0] videoAddr,
  output logic colourRef,
  output logic phaseClk,
  output logic quadClk,
  output logic [7:0] muxedMemAddr,
  output logic [2:0] physBankAddr,
  output logic rowStrobeN,
  output logic colStrobeN,
  output logic bank0_write_enable_nOut,
  output logic bank1_write_enable_nOut,
  output logic [2:0] selectCode,
  output logic romEnableN,
  output logic refreshActive
);
  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [2:0] oscSync_r;
  logic [1:0] speedSync_r;
  logic [1:0] rwSync_r;
  logic [15:0] addrMeta_r;
  logic [15:0] addrSync_r;
  logic [7:0] dataMeta_r;
  logic [7:0] dataSync_r;
  logic [15:0] vidMeta_r;
  logic [15:0] vidSync_r;

  // Two-flop synchronisers; third oscillator flop only feeds edge detection
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      oscSync_r <= 3'h0;
      speedSync_r <= 2'h0;
      rwSync_r <= 2'h3;
      addrMeta_r <= 16'h0000;
      addrSync_r <= 16'h0000;
      dataMeta_r <= 8'h00;
      dataSync_r <= 8'h00;
      vidMeta_r <= 16'h0000;
      vidSync_r <= 16'h0000;
    end else begin
      oscSync_r <= {oscSync_r[1:0], masterOsc};
      speedSync_r <= {speedSync_r[0], fastSpeed};
      rwSync_r <= {rwSync_r[0], cpuReadNotWrite};
      addrMeta_r <= cpuAddr;
      addrSync_r <= addrMeta_r;
      dataMeta_r <= cpuData;
      dataSync_r <= dataMeta_r;
      vidMeta_r <= videoAddr;
      vidSync_r <= vidMeta_r;
    end
  end

  logic oscRise;
  assign oscRise = oscSync_r[1] & ~oscSync_r[2];

  ////////////////////////////////////////////////////////////////////////////
  // Clock dividers
  logic [2:0] masterCnt_r;
  logic [2:0] quarterEnd;
  logic [2:0] quarterCnt_r;
  logic [1:0] procPhase_r;
  logic fast_r;

  // Master oscillator divided by eight
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      masterCnt_r <= 3'h0;
      colourRef <= 1'b0;
    end else if (oscRise) begin
      masterCnt_r <= masterCnt_r + 3'h1;
      colourRef <= masterCnt_r[2];
    end
  end
  // Last oscillator rise of a quarter period, per speed
  assign quarterEnd = fast_r ? 3'(stdc_pkg::FAST_QUARTER - 1) : 3'(stdc_pkg::SLOW_QUARTER - 1);

  // Quarter-period counter: fast mode makes each quarter half as long
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      quarterCnt_r <= 3'h0;
      procPhase_r <= 2'h0;
      fast_r <= 1'b0;
    end else if (oscRise) begin
      if (quarterCnt_r == quarterEnd) begin
        quarterCnt_r <= 3'h0;
        procPhase_r <= procPhase_r + 2'h1;
        if (procPhase_r[1:0] == 2'h3) begin
          fast_r <= speedSync_r[1];
        end
      end else begin
        quarterCnt_r <= quarterCnt_r + 3'h1;
      end
    end
  end
  // Quarter steps: 3 Q rises, 0 E rises, 1 Q falls, 2 E falls
  logic quarterTick;
  assign quarterTick = oscRise && (quarterCnt_r == quarterEnd);
  // Phase clock level after this edge, so registered gates follow it without lag
  logic phaseClk_nxt;
  assign phaseClk_nxt = quarterTick ? (procPhase_r == 2'h0 || procPhase_r == 2'h1) : phaseClk;

  // Processor clocks, half duty with quadrature lead
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      phaseClk <= 1'b0;
      quadClk <= 1'b0;
    end else if (quarterTick) begin
      quadClk <= (procPhase_r[1:0] == 2'h3) || (procPhase_r[1:0] == 2'h0);
      phaseClk <= (procPhase_r[1:0] == 2'h0) || (procPhase_r[1:0] == 2'h1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Paging unit
  logic pageHit;
  logic [2:0] pageUpper;
  logic [stdc_pkg::PAGE_BITS-1:0] pageOut;
  assign pageHit = (addrSync_r >= stdc_pkg::PAGE_BASE) && (addrSync_r <= stdc_pkg::PAGE_LAST);

  stdc_page_mem #(
    .DEPTH(stdc_pkg::PAGE_ENTRIES),
    .WIDTH(stdc_pkg::PAGE_BITS)
  ) pageMem (
    .mclk(mclk),
    .writeEn(pageHit && !rwSync_r[1] && quarterTick && phaseClk && procPhase_r[1:0] == 2'h1),
    .writeIdx(addrSync_r[3:0]),
    .writeData(dataSync_r[stdc_pkg::PAGE_BITS-1:0]),
    .readIdx({1'b0, addrSync_r[15:stdc_pkg::PAGE_SHIFT]}),
    .readData(pageOut)
  );
  // Top three entry bits are the physical bank bits above the processor space
  assign pageUpper = pageOut[stdc_pkg::PAGE_BITS-1:stdc_pkg::PAGE_BITS-3];

  ////////////////////////////////////////////////////////////////////////////
  // Refresh scheduling
  logic [$clog2(REFRESH_PERIOD+1)-1:0] refreshTimer_r;
  logic refreshDue_r;
  logic [7:0] refreshRow_r;
  stdc_pkg::stdc_phase_t state_r;

  // Refresh request every window/rows cycles, served in the next video slot
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      refreshTimer_r <= '0;
      refreshDue_r <= 1'b0;
    end else begin
      if (refreshTimer_r == $bits(refreshTimer_r)'(REFRESH_PERIOD - 1)) begin
        refreshTimer_r <= '0;
      end else begin
        refreshTimer_r <= refreshTimer_r + 1'b1;
      end
      if (refreshTimer_r == $bits(refreshTimer_r)'(REFRESH_PERIOD - 1)) begin
        refreshDue_r <= 1'b1;
      end else if (state_r == stdc_pkg::ST_DONE && refreshActive) begin
        refreshDue_r <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // DRAM access sequencer: one strobed access in each half of E
  logic slotCpu_r;
  logic slotWrite_r;
  logic slotBank_r;
  logic [15:0] slotAddr_r;

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= stdc_pkg::ST_IDLE;
      slotCpu_r <= 1'b0;
      slotWrite_r <= 1'b0;
      slotBank_r <= 1'b0;
      slotAddr_r <= 16'h0000;
      refreshActive <= 1'b0;
    end else begin
      unique case (state_r)
        stdc_pkg::ST_IDLE: begin
          // Start of each E half, on the quarter tick where E rises or falls
          if (quarterTick && procPhase_r[0] == 1'b0) begin
            state_r <= stdc_pkg::ST_ROW;
            slotCpu_r <= (procPhase_r[1:0] == 2'h0);
            refreshActive <= (procPhase_r[1:0] == 2'h2) && refreshDue_r;
            slotWrite_r <= (procPhase_r[1:0] == 2'h0) && !rwSync_r[1]
                           && addrSync_r < stdc_pkg::ROM_BASE;
            // Lowest paged bank bit picks which 64K bank sees the write
            slotBank_r <= pageUpper[0];
            slotAddr_r <= (procPhase_r[1:0] == 2'h0) ? addrSync_r
                          : (refreshDue_r ? {8'h00, refreshRow_r} : vidSync_r);
          end
        end
        stdc_pkg::ST_ROW: if (oscRise) state_r <= stdc_pkg::ST_COL;
        stdc_pkg::ST_COL: if (oscRise) state_r <= stdc_pkg::ST_HOLD;
        stdc_pkg::ST_HOLD: if (quarterTick) state_r <= stdc_pkg::ST_DONE;
        stdc_pkg::ST_DONE: begin
          state_r <= stdc_pkg::ST_IDLE;
          refreshActive <= 1'b0;
        end
      endcase
    end
  end

  // Refresh row counter, advances after each refresh and wraps
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      refreshRow_r <= 8'h00;
    end else if (state_r == stdc_pkg::ST_DONE && refreshActive) begin
      refreshRow_r <= refreshRow_r + 8'h01;
    end
  end

  // DRAM pins registered from the sequencer state
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      muxedMemAddr <= 8'h00;
      rowStrobeN <= 1'b1;
      colStrobeN <= 1'b1;
      bank0_write_enable_nOut <= 1'b1;
      bank1_write_enable_nOut <= 1'b1;
      physBankAddr <= 3'h0;
    end else begin
      rowStrobeN <= !(state_r == stdc_pkg::ST_ROW || state_r == stdc_pkg::ST_COL
                      || state_r == stdc_pkg::ST_HOLD);
      colStrobeN <= !((state_r == stdc_pkg::ST_COL || state_r == stdc_pkg::ST_HOLD)
                      && !refreshActive);
      muxedMemAddr <= (state_r == stdc_pkg::ST_ROW) ? slotAddr_r[7:0]
                      : slotAddr_r[15:8];
      // Write enable falls with row strobe, leading column strobe by one oscillator rise, only in CPU writes
      bank0_write_enable_nOut <= !(slotCpu_r && slotWrite_r && !slotBank_r
        && state_r != stdc_pkg::ST_IDLE && state_r != stdc_pkg::ST_DONE);
      bank1_write_enable_nOut <= !(slotCpu_r && slotWrite_r && slotBank_r
        && state_r != stdc_pkg::ST_IDLE && state_r != stdc_pkg::ST_DONE);
      physBankAddr <= slotCpu_r ? pageUpper : 3'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Device select and ROM gating
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      selectCode <= stdc_pkg::SEL_RAM;
      romEnableN <= 1'b1;
    end else begin
      if (addrSync_r >= stdc_pkg::ADAPT_BASE && addrSync_r <= stdc_pkg::ADAPT_LAST) begin
        selectCode <= stdc_pkg::SEL_ADAPT;
      end else if (addrSync_r >= stdc_pkg::CART_BASE && addrSync_r < stdc_pkg::IO_BASE) begin
        selectCode <= stdc_pkg::SEL_CART;
      end else if (addrSync_r >= stdc_pkg::ROM_BASE && addrSync_r < stdc_pkg::CART_BASE) begin
        selectCode <= stdc_pkg::SEL_ROM;
      end else begin
        selectCode <= stdc_pkg::SEL_RAM;
      end
      romEnableN <= !(phaseClk_nxt && rwSync_r[1] && addrSync_r >= stdc_pkg::ROM_BASE
                      && addrSync_r < stdc_pkg::CART_BASE);
    end
  end
endmodule : stdc_top
